// >>> design/fwd_tables_cfg.svh
// Purpose: Offsets, field positions, reset values and sizes of the forwarding tables
// Assumes: Word-wide register port, one register per port map or default VLAN index, three per address table index
// Notes:   Definitions only
`ifndef FWD_TABLES_CFG_SVH
`define FWD_TABLES_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_VLAN_PORT_MAP_SEL      8'h00
`define OFS_VLAN_PORT_MAP_DATA     8'h01
`define OFS_PDV_SEL       8'h02
`define OFS_PDV_DATA      8'h03
`define OFS_AT_SEL        8'h04
`define OFS_AT_W0         8'h05
`define OFS_AT_W1         8'h06
`define OFS_AT_W2         8'h07
`define OFS_AT_CMD        8'h08
`define OFS_AT_STAT       8'h09
`define OFS_GRP_COUNT     8'h0a

// ----------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------
`define VLAN_PORT_MAP_MASK         32'h07ffffff
`define PDV_MASK          32'h0000efff
`define VLAN_PORT_MAP_TAG_LSB      0
`define VLAN_PORT_MAP_MBR_LSB      13
`define VLAN_PORT_MAP_REMOTE_BIT   26
`define PDV_VID_LSB       0
`define PDV_PRI_LSB       13
`define UC_STAMP_BIT      0
`define UC_DFILT_BIT      21
`define UC_SFILT_BIT      22
`define UC_SPEED_BIT      25
`define UC_PORT_LSB       17
`define MC_VIDX_LSB       0
`define MC_CPU_BIT        8
`define MC_VID_LSB        16

// ----------------------------------------------------------------
// Sizes and commands
// ----------------------------------------------------------------
`define VLAN_PORT_MAP_DEPTH        256
`define PORT_COUNT        13
`define AT_DEPTH          2048
`define MAX_MC_GROUPS     9'h0ff
`define CMD_READ          2'h1
`define CMD_WRITE         2'h2
`define CMD_CLEAR         2'h3
`define IGMP_PROTO        8'h02
`define MC_MAC_PREFIX     24'h01005e
`define RESET_ZERO        32'h00000000

`endif

// >>> design/fwd_tables_pkg.sv
// Purpose: Types shared by the forwarding tables
// Assumes: Nothing
// Notes:   Constants live in the cfg header
package fwd_tables_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01,
    ST_LEARN  = 2'b10
  } eng_state_e;
  typedef logic [10:0] at_index_t;
  typedef logic [7:0]  vidx_t;
endpackage

// >>> design/vlan_ipmc_forward_tables.sv
// Purpose: VLAN port map, port default VLAN, frame classifier and address lookup table
// Assumes: One frame lookup request per cycle from the search engine side
// Notes:   Address table entries are three words; all three are stored
`timescale 1ns/1ps
`default_nettype none
`include "fwd_tables_cfg.svh"

module vlan_ipmc_forward_tables
  import fwd_tables_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        frm_valid,
  input  wire logic [3:0]  frm_port,
  input  wire logic        frm_tagged,
  input  wire logic [11:0] frm_vid,
  input  wire logic [2:0]  frm_pri,
  input  wire logic [47:0] frm_dmac,
  input  wire logic [7:0]  frm_proto,
  input  wire logic [31:0] frm_dip,
  input  wire logic [10:0] frm_hash,
  input  wire logic [7:0]  frm_vidx,
  input  wire logic        learn_req,
  input  wire logic [10:0] learn_index,
  input  wire logic [31:0] learn_w1,
  input  wire logic        age_req,
  input  wire logic [10:0] age_index,
  output logic             res_valid,
  output logic             res_to_cpu,
  output logic             res_ipmc,
  output logic             res_hit,
  output logic [11:0]      res_vid,
  output logic [2:0]       res_pri,
  output logic [12:0]      res_ports,
  output logic [12:0]      res_tag,
  output logic             res_remote,
  output logic             res_cpu_member,
  output logic [10:0]      res_next
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] vlan_port_map_mem [0:`VLAN_PORT_MAP_DEPTH-1];
  logic [31:0] pdv_mem  [0:`PORT_COUNT-1];
  logic [31:0] at_w0    [0:`AT_DEPTH-1];
  logic [31:0] at_w1    [0:`AT_DEPTH-1];
  logic [31:0] at_w2    [0:`AT_DEPTH-1];
  logic [7:0]  vlan_port_map_sel_reg;
  logic [3:0]  pdv_sel_reg;
  at_index_t   at_sel_reg;
  logic [31:0] at_w0_reg, at_w1_reg, at_w2_reg;
  logic [8:0]  grp_count_reg;
  logic        grp_full_reg;
  eng_state_e  state_reg;
  logic [1:0]  cmd_reg;
  logic        learn_pend_reg;
  at_index_t   learn_idx_reg;
  logic [31:0] learn_w1_reg;

  function automatic logic is_mc_mac(input logic [47:0] mac);
    is_mc_mac = (mac[47:24] == `MC_MAC_PREFIX);
  endfunction

  // ----------------------------------------------------------------
  // Frame classification and lookup
  // ----------------------------------------------------------------
  logic        igmp_c, ipmc_c, hit_c;
  logic [11:0] vid_c;
  logic [31:0] pdv_c, ent0_c, ent1_c, map_c;
  logic [7:0]  vidx_c;

  always_comb begin
    pdv_c  = (frm_port < 4'(`PORT_COUNT)) ? pdv_mem[frm_port] : `RESET_ZERO;
    vid_c  = frm_tagged ? frm_vid : pdv_c[`PDV_VID_LSB +: 12];
    igmp_c = is_mc_mac(frm_dmac) && (frm_proto == `IGMP_PROTO)
             && (frm_dip[31:8] == 24'he00000);
    ipmc_c = is_mc_mac(frm_dmac) && (frm_dip >= 32'he0000100)
             && (frm_dip <= 32'hefffffff) && !igmp_c;
    ent0_c = at_w0[frm_hash];
    ent1_c = at_w1[frm_hash];
    hit_c  = ipmc_c && (ent0_c == frm_dip)
             && (ent1_c[`MC_VID_LSB +: 12] == vid_c);
    vidx_c = hit_c ? ent1_c[`MC_VIDX_LSB +: 8] : frm_vidx;
    map_c  = vlan_port_map_mem[vidx_c];
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      res_valid      <= 1'b0;
      res_to_cpu     <= 1'b0;
      res_ipmc       <= 1'b0;
      res_hit        <= 1'b0;
      res_vid        <= 12'h000;
      res_pri        <= 3'h0;
      res_ports      <= 13'h0000;
      res_tag        <= 13'h0000;
      res_remote     <= 1'b0;
      res_cpu_member <= 1'b0;
      res_next       <= 11'h000;
    end else begin
      res_valid      <= frm_valid;
      res_to_cpu     <= frm_valid && igmp_c;
      res_ipmc       <= frm_valid && ipmc_c;
      res_hit        <= frm_valid && hit_c;
      res_vid        <= vid_c;
      res_pri        <= frm_tagged ? frm_pri : pdv_c[`PDV_PRI_LSB +: 3];
      res_ports      <= map_c[`VLAN_PORT_MAP_MBR_LSB +: 13];
      res_tag        <= map_c[`VLAN_PORT_MAP_TAG_LSB +: 13];
      res_remote     <= map_c[`VLAN_PORT_MAP_REMOTE_BIT];
      res_cpu_member <= hit_c && ent1_c[`MC_CPU_BIT];
      res_next       <= at_w2[frm_hash][10:0];
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      vlan_port_map_sel_reg <= 8'h00;
      pdv_sel_reg  <= 4'h0;
      at_sel_reg   <= 11'h000;
      cmd_reg      <= 2'h0;
    end else begin
      cmd_reg <= (state_reg == ST_ACCESS) ? 2'h0 : cmd_reg;
      if (reg_wr) begin
        if (reg_addr == `OFS_VLAN_PORT_MAP_SEL) begin
          vlan_port_map_sel_reg <= reg_wdata[7:0];
        end else if (reg_addr == `OFS_PDV_SEL) begin
          pdv_sel_reg <= reg_wdata[3:0];
        end else if (reg_addr == `OFS_AT_SEL) begin
          at_sel_reg <= reg_wdata[10:0];
        end else if (reg_addr == `OFS_AT_CMD && state_reg == ST_IDLE && cmd_reg == 2'h0) begin
          cmd_reg <= reg_wdata[1:0];
        end
      end
    end
  end

  logic new_grp_c;
  assign new_grp_c = (state_reg == ST_ACCESS) && (cmd_reg == `CMD_WRITE) && at_w1_reg[`MC_VID_LSB +: 12] != 12'h000
                     && !at_w1[at_sel_reg][`MC_CPU_BIT + 23] && !grp_full_reg && at_w0_reg[31:28] == 4'he;

  // Port map and default VLAN storage
  always_ff @(posedge clk_sys) begin
    if (reg_wr && reg_addr == `OFS_VLAN_PORT_MAP_DATA) begin
      vlan_port_map_mem[vlan_port_map_sel_reg] <= reg_wdata & `VLAN_PORT_MAP_MASK;
    end else if (new_grp_c && at_w0[at_sel_reg] != at_w0_reg) begin
      vlan_port_map_mem[at_w1_reg[`MC_VIDX_LSB +: 8]] <= vlan_port_map_mem[vlan_port_map_sel_reg];
    end
    if (reg_wr && reg_addr == `OFS_PDV_DATA && pdv_sel_reg < 4'(`PORT_COUNT)) begin
      pdv_mem[pdv_sel_reg] <= reg_wdata & `PDV_MASK;
    end
  end

  // Staging words for table commands
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      at_w0_reg <= `RESET_ZERO;
      at_w1_reg <= `RESET_ZERO;
      at_w2_reg <= `RESET_ZERO;
    end else if (state_reg == ST_ACCESS && cmd_reg == `CMD_READ) begin
      at_w0_reg <= at_w0[at_sel_reg];
      at_w1_reg <= at_w1[at_sel_reg];
      at_w2_reg <= at_w2[at_sel_reg];
    end else if (reg_wr) begin
      if (reg_addr == `OFS_AT_W0) begin
        at_w0_reg <= reg_wdata;
      end else if (reg_addr == `OFS_AT_W1) begin
        at_w1_reg <= reg_wdata;
      end else if (reg_addr == `OFS_AT_W2) begin
        at_w2_reg <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Table engine: commands, learning and aging
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cmd_reg != 2'h0) begin
            state_reg <= ST_ACCESS;
          end else if (learn_pend_reg) begin
            state_reg <= ST_LEARN;
          end
        end
        ST_ACCESS: state_reg <= ST_IDLE;
        ST_LEARN:  state_reg <= ST_IDLE;
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end

  // Learn requests taken while the lookup path is busy are deferred
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      learn_pend_reg <= 1'b0;
      learn_idx_reg  <= 11'h000;
      learn_w1_reg   <= `RESET_ZERO;
    end else if (learn_req && frm_valid) begin
      learn_pend_reg <= 1'b1;
      learn_idx_reg  <= learn_index;
      learn_w1_reg   <= learn_w1;
    end else if (state_reg == ST_LEARN) begin
      learn_pend_reg <= 1'b0;
    end
  end

  logic cmd_go_c;
  logic res_hit_uc_c;
  assign cmd_go_c = (state_reg == ST_ACCESS);
  assign res_hit_uc_c = frm_valid && !frm_dmac[40] && (at_w0[frm_hash][31:8] == frm_dmac[23:0])
                        && !(cmd_go_c && cmd_reg != `CMD_READ) && !(learn_req && !frm_valid);

  always_ff @(posedge clk_sys) begin
    if (cmd_go_c && cmd_reg == `CMD_WRITE) begin
      at_w0[at_sel_reg] <= at_w0_reg;
      at_w1[at_sel_reg] <= at_w1_reg;
      at_w2[at_sel_reg] <= at_w2_reg;
    end else if (cmd_go_c && cmd_reg == `CMD_CLEAR) begin
      at_w0[at_sel_reg] <= `RESET_ZERO;
      at_w1[at_sel_reg] <= `RESET_ZERO;
      at_w2[at_sel_reg] <= `RESET_ZERO;
    end else if (learn_req && !frm_valid) begin
      at_w1[learn_index] <= learn_w1;
    end else if (state_reg == ST_LEARN) begin
      at_w1[learn_idx_reg] <= learn_w1_reg;
    end
    if (res_hit_uc_c) begin
      at_w0[frm_hash][`UC_STAMP_BIT] <= 1'b1;
    end else if (age_req) begin
      at_w0[age_index][`UC_STAMP_BIT] <= 1'b0;
    end
  end

  // Group counter, capped at the group limit
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      grp_count_reg <= 9'h000;
      grp_full_reg  <= 1'b0;
    end else if (new_grp_c && at_w0[at_sel_reg] != at_w0_reg) begin
      grp_count_reg <= grp_count_reg + 9'h001;
      grp_full_reg  <= (grp_count_reg + 9'h001) >= `MAX_MC_GROUPS;
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata <= `RESET_ZERO;
    end else if (reg_rd) begin
      if (reg_addr == `OFS_VLAN_PORT_MAP_SEL) begin
        reg_rdata <= {24'h000000, vlan_port_map_sel_reg};
      end else if (reg_addr == `OFS_VLAN_PORT_MAP_DATA) begin
        reg_rdata <= vlan_port_map_mem[vlan_port_map_sel_reg] & `VLAN_PORT_MAP_MASK;
      end else if (reg_addr == `OFS_PDV_SEL) begin
        reg_rdata <= {28'h0000000, pdv_sel_reg};
      end else if (reg_addr == `OFS_PDV_DATA) begin
        reg_rdata <= (pdv_sel_reg < 4'(`PORT_COUNT)) ? (pdv_mem[pdv_sel_reg] & `PDV_MASK) : `RESET_ZERO;
      end else if (reg_addr == `OFS_AT_SEL) begin
        reg_rdata <= {21'h000000, at_sel_reg};
      end else if (reg_addr == `OFS_AT_W0) begin
        reg_rdata <= at_w0_reg;
      end else if (reg_addr == `OFS_AT_W1) begin
        reg_rdata <= at_w1_reg;
      end else if (reg_addr == `OFS_AT_W2) begin
        reg_rdata <= at_w2_reg;
      end else if (reg_addr == `OFS_AT_STAT) begin
        reg_rdata <= {29'h00000000, grp_full_reg, learn_pend_reg, state_reg != ST_IDLE};
      end else if (reg_addr == `OFS_GRP_COUNT) begin
        reg_rdata <= {23'h000000, grp_count_reg};
      end else begin
        reg_rdata <= `RESET_ZERO;
      end
    end else begin
      reg_rdata <= `RESET_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_igmp_cpu;
    @(posedge clk_sys) disable iff (!nrst)
      (frm_valid && is_mc_mac(frm_dmac) && frm_proto == 8'h02 && frm_dip[31:8] == 24'he00000) |=> res_to_cpu;
  endproperty
  a_igmp_cpu: assert property (p_igmp_cpu) else $error("IGMP frame not sent to CPU");

  property p_ipmc_range;
    @(posedge clk_sys) disable iff (!nrst)
      res_ipmc |-> $past(frm_dip) >= 32'he0000100 && $past(frm_dip) <= 32'hefffffff;
  endproperty
  a_ipmc_range: assert property (p_ipmc_range) else $error("Multicast data outside range");

  property p_not_both;
    @(posedge clk_sys) disable iff (!nrst) !(res_to_cpu && res_ipmc);
  endproperty
  a_not_both: assert property (p_not_both) else $error("Frame both IGMP and data");

  property p_hit_ipmc;
    @(posedge clk_sys) disable iff (!nrst) res_hit |-> res_ipmc && res_valid;
  endproperty
  a_hit_ipmc: assert property (p_hit_ipmc) else $error("Hit without multicast data");

  property p_untag_vid;
    @(posedge clk_sys) disable iff (!nrst)
      (frm_valid && !frm_tagged && frm_port == 4'hc) |=> res_vid == $past(pdv_mem[12][11:0]);
  endproperty
  a_untag_vid: assert property (p_untag_vid) else $error("Untagged VLAN ID wrong");

  property p_vlan_port_map_rsvd;
    @(posedge clk_sys) disable iff (!nrst)
      reg_rd && reg_addr == `OFS_VLAN_PORT_MAP_DATA |=> reg_rdata[31:27] == 5'h00;
  endproperty
  a_vlan_port_map_rsvd: assert property (p_vlan_port_map_rsvd) else $error("Reserved map bits nonzero");

  property p_grp_cap;
    @(posedge clk_sys) disable iff (!nrst) grp_count_reg <= 9'h0ff;
  endproperty
  a_grp_cap: assert property (p_grp_cap) else $error("Group count over limit");

  property p_cmd_done;
    @(posedge clk_sys) disable iff (!nrst)
      cmd_reg != 2'h0 && state_reg == ST_IDLE |=> state_reg == ST_ACCESS ##1 state_reg == ST_IDLE;
  endproperty
  a_cmd_done: assert property (p_cmd_done) else $error("Table command not finished");

  property p_cpu_member;
    @(posedge clk_sys) disable iff (!nrst) res_cpu_member |-> res_hit;
  endproperty
  a_cpu_member: assert property (p_cpu_member) else $error("CPU member without hit");

endmodule

`default_nettype wire

// >>> testbench/fwd_partner.sv
// Purpose: Search engine side model: frame lookups, hardware learns, aging
// Assumes: Requests change just after a rising edge
// Notes:   Released destination MAC and IP fields show their inverse
`timescale 1ns/1ps
`default_nettype none
module fwd_partner (
  input  wire logic   clk_sys,
  output logic        frm_valid,
  output logic [3:0]  frm_port,
  output logic        frm_tagged,
  output logic [11:0] frm_vid,
  output logic [2:0]  frm_pri,
  output logic [47:0] frm_dmac,
  output logic [7:0]  frm_proto,
  output logic [31:0] frm_dip,
  output logic [10:0] frm_hash,
  output logic [7:0]  frm_vidx,
  output logic        learn_req,
  output logic [10:0] learn_index,
  output logic [31:0] learn_w1,
  output logic        age_req,
  output logic [10:0] age_index
);
  initial begin
    {frm_valid, frm_tagged, frm_vid, frm_dmac, frm_proto, frm_dip, frm_hash, frm_vidx} = '0;
    {learn_req, learn_index, learn_w1, age_req, age_index} = '0;
    frm_port = 4'hc;
    frm_pri = 3'h3;
  end
  // One lookup pulse with its fields
  task automatic lookup(input logic [47:0] da, input logic [31:0] ip, input logic [7:0] pr,
                        input logic tg, input logic [11:0] vid, input logic [10:0] h, input logic [7:0] vx);
    @(posedge clk_sys);
    frm_valid <= 1'b1;
    {frm_dmac, frm_dip, frm_proto, frm_tagged, frm_vid, frm_hash, frm_vidx} <= {da, ip, pr, tg, vid, h, vx};
    @(posedge clk_sys);
    frm_valid <= 1'b0;
    {frm_dmac, frm_dip} <= ~{frm_dmac, frm_dip};
  endtask
  // Learn pulse; busy raises a lookup beside it so the engine must do it
  task automatic learn(input logic [10:0] idx, input logic [31:0] w, input logic busy);
    @(posedge clk_sys);
    {learn_req, frm_valid, learn_index, learn_w1} <= {1'b1, busy, idx, w};
    @(posedge clk_sys);
    {learn_req, frm_valid} <= 2'b00;
    learn_w1 <= ~w;
  endtask
  // Aging pulse for one entry
  task automatic age(input logic [10:0] idx);
    @(posedge clk_sys);
    {age_req, age_index} <= {1'b1, idx};
    @(posedge clk_sys);
    age_req <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/vlan_ipmc_forward_tables_test.sv
// Purpose: Self-checking bench for the forwarding tables
// Assumes: Register read data one cycle after the strobe
// Notes:   Classifier cases are table rows
`timescale 1ns/1ps
`default_nettype none
`include "fwd_tables_cfg.svh"
module vlan_ipmc_forward_tables_test;
  logic        clk_sys, nrst, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, rd, gc;
  wire  [31:0] reg_rdata, frm_dip, learn_w1;
  wire         frm_valid, frm_tagged, learn_req, age_req;
  wire         res_valid, res_to_cpu, res_ipmc, res_hit, res_remote, res_cpu_member;
  wire  [3:0]  frm_port;
  wire  [2:0]  frm_pri, res_pri;
  wire  [7:0]  frm_proto, frm_vidx;
  wire  [10:0] frm_hash, learn_index, age_index, res_next;
  wire  [11:0] frm_vid, res_vid;
  wire  [12:0] res_ports, res_tag;
  wire  [47:0] frm_dmac;
  int          miscompares, tests_run;
  localparam logic [31:0] V5 = 32'hf5b3c1a7;
  localparam logic [31:0] V7 = 32'h2c4e8a19;
  typedef struct {logic [47:0] da; logic [31:0] ip; logic [7:0] pr; logic cpu; logic mc;} row_s;
  row_s rows [8] = '{'{48'h01005e000005, 32'he0000005, 8'h02, 1'b1, 1'b0},
                     '{48'h01005e000005, 32'he0000005, 8'h11, 1'b0, 1'b0},
                     '{48'h01005e000100, 32'he0000100, 8'h11, 1'b0, 1'b1},
                     '{48'h01005effffff, 32'hefffffff, 8'h11, 1'b0, 1'b1},
                     '{48'h01005e000000, 32'hf0000000, 8'h11, 1'b0, 1'b0},
                     '{48'h01005f000005, 32'he0000005, 8'h02, 1'b0, 1'b0},
                     '{48'h01005e0000ff, 32'he00000ff, 8'h11, 1'b0, 1'b0},
                     '{48'h01005e000101, 32'he0000101, 8'h02, 1'b0, 1'b1}};

  vlan_ipmc_forward_tables uut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .frm_valid, .frm_port, .frm_tagged, .frm_vid, .frm_pri, .frm_dmac, .frm_proto, .frm_dip, .frm_hash,
    .frm_vidx, .learn_req, .learn_index, .learn_w1, .age_req, .age_index, .res_valid, .res_to_cpu,
    .res_ipmc, .res_hit, .res_vid, .res_pri, .res_ports, .res_tag, .res_remote, .res_cpu_member, .res_next);
  fwd_partner se (.clk_sys, .frm_valid, .frm_port, .frm_tagged, .frm_vid, .frm_pri, .frm_dmac,
    .frm_proto, .frm_dip, .frm_hash, .frm_vidx, .learn_req, .learn_index, .learn_w1, .age_req, .age_index);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic put(input logic [7:0] sa, input logic [7:0] s, input logic [7:0] da, input logic [31:0] d);
    wr(sa, 32'(s));
    wr(da, d);
  endtask
  task automatic get(input logic [7:0] sa, input logic [7:0] s, input logic [7:0] da, input logic [31:0] e);
    wr(sa, 32'(s));
    rdr(da);
    chk(rd, e);
  endtask
  task automatic cmd(input logic [1:0] op, input logic [10:0] idx);
    wr(`OFS_AT_SEL, 32'(idx));
    wr(`OFS_AT_CMD, 32'(op));
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic look(input logic [47:0] da, input logic [31:0] ip, input logic [7:0] pr,
                      input logic tg, input logic [11:0] vid, input logic [10:0] h);
    se.lookup(da, ip, pr, tg, vid, h, 8'h07);
    #1;
    chk(32'(res_valid), 32'h1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
    chk(reg_rdata, 32'h0);
    chk(32'(res_valid), 32'h0);
    rdr(8'h3c);
    chk(rd, 32'h0);
    put(`OFS_VLAN_PORT_MAP_SEL, 8'h00, `OFS_VLAN_PORT_MAP_DATA, 32'hffffffff);
    put(`OFS_VLAN_PORT_MAP_SEL, 8'hff, `OFS_VLAN_PORT_MAP_DATA, 32'h12345678);
    put(`OFS_VLAN_PORT_MAP_SEL, 8'h07, `OFS_VLAN_PORT_MAP_DATA, V7);
    put(`OFS_VLAN_PORT_MAP_SEL, 8'h05, `OFS_VLAN_PORT_MAP_DATA, V5);
    put(`OFS_PDV_SEL, 8'h0c, `OFS_PDV_DATA, 32'h0000f123);
    get(`OFS_VLAN_PORT_MAP_SEL, 8'h00, `OFS_VLAN_PORT_MAP_DATA, 32'h07ffffff);
    get(`OFS_VLAN_PORT_MAP_SEL, 8'hff, `OFS_VLAN_PORT_MAP_DATA, 32'h02345678);
    get(`OFS_VLAN_PORT_MAP_SEL, 8'h07, `OFS_VLAN_PORT_MAP_DATA, V7 & 32'h07ffffff);
    get(`OFS_PDV_SEL, 8'h0c, `OFS_PDV_DATA, 32'h0000e123);
    cmd(`CMD_CLEAR, 11'h7ff);
    foreach (rows[i]) begin
      look(rows[i].da, rows[i].ip, rows[i].pr, 1'b0, 12'h0, 11'h7ff);
      chk(32'(res_to_cpu), 32'(rows[i].cpu));
      chk(32'(res_ipmc), 32'(rows[i].mc));
      chk(32'(res_vid), 32'h123);
      chk(32'(res_pri), 32'h7);
    end
    look(48'h020000000001, 32'h0, 8'h0, 1'b1, 12'h456, 11'h7ff);
    chk(32'(res_vid), 32'h456);
    chk(32'(res_pri), 32'h3);
    chk(32'(res_ports), 32'(V7[25:13]));
    chk(32'(res_tag), 32'(V7[12:0]));
    // Unicast entry: stamp, filters, speed, learning, clearing
    wr(`OFS_AT_W0, 32'habcdef00);
    wr(`OFS_AT_W1, 32'h02660000);
    wr(`OFS_AT_W2, 32'h0);
    cmd(`CMD_WRITE, 11'h0a3);
    look(48'h020000abcdef, 32'h0, 8'h0, 1'b0, 12'h0, 11'h0a3);
    chk(32'({res_hit, res_ipmc, res_to_cpu}), 32'h0);
    cmd(`CMD_READ, 11'h0a3);
    rdr(`OFS_AT_W0);
    chk(rd, 32'habcdef01);
    rdr(`OFS_AT_W1);
    chk(rd, 32'h02660000);
    se.age(11'h0a3);
    cmd(`CMD_READ, 11'h0a3);
    rdr(`OFS_AT_W0);
    chk(rd, 32'habcdef00);
    se.learn(11'h0a3, 32'h00060000, 1'b1);
    repeat (4) @(posedge clk_sys);
    cmd(`CMD_READ, 11'h0a3);
    rdr(`OFS_AT_W1);
    chk(rd, 32'h00060000);
    cmd(`CMD_CLEAR, 11'h0a3);
    look(48'h020000abcdef, 32'h0, 8'h0, 1'b0, 12'h0, 11'h0a3);
    cmd(`CMD_READ, 11'h0a3);
    rdr(`OFS_AT_W0);
    chk(rd, 32'h0);
    // Multicast group entry
    cmd(`CMD_CLEAR, 11'h155);
    rdr(`OFS_GRP_COUNT);
    gc = rd;
    wr(`OFS_VLAN_PORT_MAP_SEL, 32'h05);
    wr(`OFS_AT_W0, 32'he0010203);
    wr(`OFS_AT_W1, 32'h01230105);
    wr(`OFS_AT_W2, 32'h000002aa);
    cmd(`CMD_WRITE, 11'h155);
    rdr(`OFS_GRP_COUNT);
    chk(rd, gc + 32'h1);
    look(48'h01005e010203, 32'he0010203, 8'h11, 1'b1, 12'h123, 11'h155);
    chk(32'({res_ipmc, res_hit, res_cpu_member, res_remote}), {28'h0, 3'h7, V5[26]});
    chk(32'(res_ports), 32'(V5[25:13]));
    chk(32'(res_tag), 32'(V5[12:0]));
    chk(32'(res_next), 32'h2aa);
    look(48'h01005e010203, 32'he0010203, 8'h11, 1'b1, 12'h124, 11'h155);
    chk(32'(res_hit), 32'h0);
    chk(32'(res_ports), 32'(V7[25:13]));
    cmd(`CMD_READ, 11'h155);
    rdr(`OFS_AT_W1);
    chk(rd, 32'h01230105);
    rdr(`OFS_AT_W2);
    chk(rd, 32'h000002aa);
    // Reset in mid-run clears results and the group counter
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
    chk(32'(res_valid), 32'h0);
    rdr(`OFS_GRP_COUNT);
    chk(rd, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
